// file: src/pds_cfg.svh
// constants for the pump dispense sequencer
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH
`define PDS_CLK_MHZ 25
`define PDS_DEB_TIME_US 1000
`define PDS_STALL_TIME_MS 4000
`define PDS_SET_MAX 10'h3e7
`define PDS_STROKES_RST 10'h000
`define PDS_RATE_RST 10'h000
`define PDS_IN_VOL_UP 0
`define PDS_IN_VOL_DN 1
`define PDS_IN_RATE_UP 2
`define PDS_IN_RATE_DN 3
`define PDS_IN_MODE 4
`define PDS_IN_DIR 5
`define PDS_IN_CLEAR 6
`define PDS_IN_RUN 7
`define PDS_IN_HALT 8
`define PDS_IN_TRIG 9
`define PDS_IN_SPIN 10
`define PDS_IN_COUNT 11
`define PDS_ADR_CTRL 6'h00
`define PDS_ADR_STATUS 6'h01
`define PDS_ADR_SETTINGS 6'h02
`define PDS_ADR_REVS 6'h03
`define PDS_ADR_IRQ_STAT 6'h04
`define PDS_ADR_IRQ_MASK 6'h05
`define PDS_CTRL_TRIG_EN 0
`define PDS_CTRL_RST 1'h1
`define PDS_EV_DONE 0
`define PDS_EV_FAULT 1
`define PDS_EV_START 2
`define PDS_EV_COUNT 3
`endif

// file: src/pds_pkg.sv
// types shared by the pump dispense sequencer
package pds_pkg;
  typedef enum logic [1:0] {
    PDS_IDLE,
    PDS_PRIME,
    PDS_METERED_DISPENSE_MODE,
    PDS_FAULT
  } pds_state_e;
endpackage : pds_pkg

// file: src/pds_panel_if.sv
// cleaned panel levels and their rising-edge pulses
`timescale 1ns/100ps
interface pds_panel_if #(parameter int N = 11);
  logic [N-1:0] clean;
  logic [N-1:0] rise;
  modport src (output clean, output rise);
  modport dst (input clean, input rise);
endinterface : pds_panel_if

// file: src/pds_debounce.sv
// synchroniser and debouncer for all panel, trigger and spindle inputs
`timescale 1ns/100ps
module pds_debounce #(
  parameter int N = 11,
  parameter int DEB_CYC = 25000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins
  input wire logic [N-1:0] raw_i,
  // cleaned side
  pds_panel_if.src pan
);
  localparam int CW = $clog2(DEB_CYC + 1);

  if (N < 1 || DEB_CYC < 1) begin : g_chk
    $error("pds_debounce: bad parameters");
  end

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] clean;
    logic [N-1:0] rise;
    logic [N-1:0][CW-1:0] cnt;
  } pds_deb_s;

  pds_deb_s s;
  pds_deb_s next_s;

  // every input gets its own filter, so a bouncing key never disturbs another
  always_comb begin
    next_s = s;
    next_s.sync1 = raw_i;
    next_s.sync2 = s.sync1;
    next_s.rise = '0;
    for (int i = 0; i < N; i++) begin
      if (s.sync2[i] == s.clean[i]) begin
        next_s.cnt[i] = '0;
      end else if (s.cnt[i] == CW'(DEB_CYC - 1)) begin
        next_s.cnt[i] = '0;
        next_s.clean[i] = s.sync2[i];
        next_s.rise[i] = s.sync2[i];
      end else begin
        next_s.cnt[i] = s.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pan.clean = s.clean;
  assign pan.rise = s.rise;
endmodule : pds_debounce

// file: src/pds_sequencer.sv
// pump dispense sequencer: panel settings, run control, revolution counting
// How it works
// - hold rotation count setting 000 to 999
// - plus key adds one, minus subtracts one
// - mode selector picks dispense or priming
// - yellow lamp lit only on active position
// - direction selector sets motor turning direction
// - fault-clear button drops fault and lamp
// - run press starts, halt press stops pump
// - green after run, red after halt, exclusive
// - rate setting drives motor speed zero to max
// - external contact trigger starts pump operation
// - either panel run or trigger starts run
// - stop motor when revolutions reach setting
// - stop decided by sensed spindle position only
// - sensed stop indexes piston into intake stroke
// - trigger acts on rising edge only
// - four seconds without spindle pulse faults
// - prime to dispense switch finishes set count
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`include "pds_cfg.svh"
module pds_sequencer import pds_pkg::*; #(
  parameter int DEB_CYC = `PDS_DEB_TIME_US * `PDS_CLK_MHZ,
  parameter int STALL_CYC = `PDS_STALL_TIME_MS * 1000 * `PDS_CLK_MHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // panel keys and selectors
  input wire logic vol_up_i,
  input wire logic vol_dn_i,
  input wire logic rate_up_i,
  input wire logic rate_dn_i,
  input wire logic mode_selector_i,
  input wire logic direction_selector_i,
  input wire logic fault_clear_i,
  input wire logic run_key_i,
  input wire logic halt_key_i,
  // external trigger and spindle sensor
  input wire logic trigger_i,
  input wire logic spindle_i,
  // panel lamps
  output logic metered_dispense_mode_lamp_o,
  output logic prime_lamp_o,
  output logic forward_flow_lamp_o,
  output logic reverse_lamp_o,
  output logic green_lamp_o,
  output logic red_lamp_o,
  output logic fault_lamp_o,
  // motor drive
  output logic motor_run_o,
  output logic motor_reverse_o,
  output logic [9:0] motor_speed_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o
);
  localparam int SW = $clog2(STALL_CYC + 1);
  localparam int EW = `PDS_EV_COUNT;

  if (STALL_CYC < 2 || DEB_CYC < 1) begin : g_chk
    $error("pds_sequencer: bad parameters");
  end

  typedef struct packed {
    pds_state_e state;
    logic [9:0] strokes;
    logic [9:0] rate;
    logic [9:0] revs;
    logic [SW-1:0] stall;
    logic trig_en;
    logic [EW-1:0] irq_stat;
    logic [EW-1:0] irq_mask;
    logic green;
    logic mode;
    logic dir;
    logic run;
    logic fault;
    logic metered_dispense_mode_lamp;
    logic fwd_lamp;
    logic red;
    logic [9:0] speed;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } pds_seq_s;

  pds_seq_s s;
  pds_seq_s next_s;
  pds_panel_if #(.N(`PDS_IN_COUNT)) pan ();

  // every pin passes the same filter, spindle included
  pds_debounce #(.N(`PDS_IN_COUNT), .DEB_CYC(DEB_CYC)) u_deb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i({spindle_i, trigger_i, halt_key_i, run_key_i, fault_clear_i,
      direction_selector_i, mode_selector_i, rate_dn_i, rate_up_i, vol_dn_i,
      vol_up_i}),
    .pan(pan)
  );

  logic spin_rise;
  logic halt_req;
  logic start_req;
  logic wb_req;
  logic [EW-1:0] ev;
  logic [EW-1:0] rd_clr;

  always_comb begin
    next_s = s;
    ev = '0;
    rd_clr = '0;
    spin_rise = pan.rise[`PDS_IN_SPIN];
    halt_req = pan.rise[`PDS_IN_HALT];
    // trigger counts only on its edge, so a held contact fires once
    start_req = pan.rise[`PDS_IN_RUN]
      || (pan.rise[`PDS_IN_TRIG] && s.trig_en);
    wb_req = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.ack = 1'b0;
    next_s.mode = pan.clean[`PDS_IN_MODE];
    next_s.dir = pan.clean[`PDS_IN_DIR];
    // lamps get their own flops so every output leaves a register
    next_s.metered_dispense_mode_lamp = !pan.clean[`PDS_IN_MODE];
    next_s.fwd_lamp = !pan.clean[`PDS_IN_DIR];
    next_s.speed = s.rate;
    // settings saturate instead of wrapping past the printed range
    if (pan.rise[`PDS_IN_VOL_UP] && s.strokes != `PDS_SET_MAX) begin
      next_s.strokes = s.strokes + 10'h001;
    end else if (pan.rise[`PDS_IN_VOL_DN] && s.strokes != 10'h000) begin
      next_s.strokes = s.strokes - 10'h001;
    end
    if (pan.rise[`PDS_IN_RATE_UP] && s.rate != `PDS_SET_MAX) begin
      next_s.rate = s.rate + 10'h001;
    end else if (pan.rise[`PDS_IN_RATE_DN] && s.rate != 10'h000) begin
      next_s.rate = s.rate - 10'h001;
    end
    unique case (s.state)
      PDS_IDLE: begin
        next_s.stall = '0;
        if (halt_req) begin
          next_s.green = 1'b0;
        end else if (start_req) begin
          next_s.green = 1'b1;
          next_s.revs = '0;
          ev[`PDS_EV_START] = 1'b1;
          if (s.mode) begin
            next_s.state = PDS_PRIME;
          end else if (s.strokes != 10'h000) begin
            next_s.state = PDS_METERED_DISPENSE_MODE;
          end
        end
      end
      PDS_PRIME, PDS_METERED_DISPENSE_MODE: begin
        if (spin_rise) begin
          next_s.stall = '0;
        end else begin
          next_s.stall = s.stall + 1'b1;
        end
        if (halt_req) begin
          next_s.state = PDS_IDLE;
          next_s.green = 1'b0;
        end else if (!spin_rise && s.stall == SW'(STALL_CYC - 1)) begin
          next_s.state = PDS_FAULT;
          ev[`PDS_EV_FAULT] = 1'b1;
        end else if (s.state == PDS_PRIME) begin
          if (!s.mode) begin
            next_s.state = PDS_METERED_DISPENSE_MODE;
            next_s.revs = '0;
          end
        end else if (spin_rise) begin
          // stop point is the sensor edge, so the piston rests in intake
          next_s.revs = s.revs + 10'h001;
          if (s.revs + 10'h001 >= s.strokes) begin
            next_s.state = PDS_IDLE;
            ev[`PDS_EV_DONE] = 1'b1;
          end
        end
      end
      PDS_FAULT: begin
        next_s.stall = '0;
        // run and trigger are ignored here
        if (pan.rise[`PDS_IN_CLEAR]) begin
          next_s.state = PDS_IDLE;
        end
      end
    endcase
    next_s.run = (next_s.state == PDS_PRIME) || (next_s.state == PDS_METERED_DISPENSE_MODE);
    next_s.fault = next_s.state == PDS_FAULT;
    next_s.red = !next_s.green;
    if (wb_req) begin
      next_s.ack = 1'b1;
      next_s.dat = '0;
      unique case (wb_adr_i[7:2])
        `PDS_ADR_CTRL: next_s.dat[`PDS_CTRL_TRIG_EN] = s.trig_en;
        `PDS_ADR_STATUS: next_s.dat[6:0] = {s.fault, s.green, s.dir, s.mode, s.run, s.state};
        `PDS_ADR_SETTINGS: next_s.dat = {6'h00, s.rate, 6'h00, s.strokes};
        `PDS_ADR_REVS: next_s.dat[9:0] = s.revs;
        `PDS_ADR_IRQ_STAT: begin
          next_s.dat[EW-1:0] = s.irq_stat;
          rd_clr = wb_we_i ? '0 : s.irq_stat;
        end
        `PDS_ADR_IRQ_MASK: next_s.dat[EW-1:0] = s.irq_mask;
        default: next_s.dat = '0;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i[7:2] == `PDS_ADR_CTRL) begin
          next_s.trig_en = wb_dat_i[`PDS_CTRL_TRIG_EN];
        end
        if (wb_adr_i[7:2] == `PDS_ADR_IRQ_MASK) begin
          next_s.irq_mask = wb_dat_i[EW-1:0];
        end
      end
    end
    // an event in the clearing read's cycle survives it
    next_s.irq_stat = (s.irq_stat & ~rd_clr) | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.state <= PDS_IDLE;
      s.strokes <= `PDS_STROKES_RST;
      s.rate <= `PDS_RATE_RST;
      s.trig_en <= `PDS_CTRL_RST;
      s.metered_dispense_mode_lamp <= 1'b1;
      s.fwd_lamp <= 1'b1;
      s.red <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign metered_dispense_mode_lamp_o = s.metered_dispense_mode_lamp;
  assign prime_lamp_o = s.mode;
  assign forward_flow_lamp_o = s.fwd_lamp;
  assign reverse_lamp_o = s.dir;
  assign green_lamp_o = s.green;
  assign red_lamp_o = s.red;
  assign fault_lamp_o = s.fault;
  assign motor_run_o = s.run;
  assign motor_reverse_o = s.dir;
  assign motor_speed_o = s.speed;
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign irq_o = s.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  strokes_range_a: assert property (s.strokes <= `PDS_SET_MAX)
    else $error("stroke setting out of range");
  plus_step_a: assert property (pan.rise[`PDS_IN_VOL_UP] && s.strokes < `PDS_SET_MAX
    |=> s.strokes == $past(s.strokes) + 10'h001)
    else $error("plus key did not add one");
  mode_lamps_a: assert property (##1 prime_lamp_o == $past(pan.clean[`PDS_IN_MODE])
    && metered_dispense_mode_lamp_o != prime_lamp_o)
    else $error("mode lamps wrong");
  dir_motor_a: assert property (##1 motor_reverse_o == $past(pan.clean[`PDS_IN_DIR])
    && forward_flow_lamp_o != reverse_lamp_o)
    else $error("direction not followed");
  clear_fault_a: assert property (s.state == PDS_FAULT && pan.rise[`PDS_IN_CLEAR]
    |=> !fault_lamp_o && !motor_run_o)
    else $error("fault clear failed");
  halt_stop_a: assert property (motor_run_o && halt_req
    |=> !motor_run_o && red_lamp_o && !green_lamp_o)
    else $error("halt did not stop");
  run_start_a: assert property (s.state == PDS_IDLE && start_req && !halt_req
    && s.mode |=> motor_run_o && green_lamp_o)
    else $error("start did not run");
  speed_track_a: assert property (##2 motor_speed_o == $past(s.rate, 1))
    else $error("speed not from rate");
  count_stop_a: assert property (s.state == PDS_METERED_DISPENSE_MODE && spin_rise && !halt_req
    && s.revs + 10'h001 == s.strokes |=> !motor_run_o ##1 !motor_run_o)
    else $error("no stop at count");
  stall_fault_a: assert property (motor_run_o && !spin_rise && !halt_req
    && s.stall == SW'(STALL_CYC - 1) |=> fault_lamp_o && !motor_run_o)
    else $error("stall not faulted");
  prime_switch_a: assert property (s.state == PDS_PRIME && !s.mode && !halt_req
    && s.stall != SW'(STALL_CYC - 1) |=> s.state == PDS_METERED_DISPENSE_MODE && s.revs == 10'h000)
    else $error("prime switch did not finish count");
  fault_hold_a: assert property (s.state == PDS_FAULT && !pan.rise[`PDS_IN_CLEAR]
    |=> s.state == PDS_FAULT && !motor_run_o)
    else $error("run accepted during fault");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_hold_a: assert property (s.state == PDS_IDLE && !pan.rise[`PDS_IN_TRIG]
    && !pan.rise[`PDS_IN_RUN] |=> !motor_run_o)
    else $error("run without a start edge");
  trig_block_a: assert property (s.state == PDS_IDLE && !s.trig_en
    && !pan.rise[`PDS_IN_RUN] |=> !motor_run_o)
    else $error("disabled trigger started run");
  lamps_excl_a: assert property (green_lamp_o != red_lamp_o)
    else $error("green and red not exclusive");
endmodule : pds_sequencer

// file: testbench/pds_spindle_model.sv
// behavioural motor drive and spindle sensor
`timescale 1ns/100ps
module pds_spindle_model #(
  parameter int PER = 20
) (
  // clock
  input wire logic clk_i,
  // motor command and fault injection
  input wire logic motor_run_i,
  input wire logic stall_i,
  // sensor
  output logic spindle_o
);
  int cnt = 0;
  // stalled or stopped spindle shows no target, so no edges reach the counter
  always @(posedge clk_i) begin
    if (!motor_run_i || stall_i) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    end
  end
  // one rising edge per turn of the spindle
  assign spindle_o = motor_run_i && !stall_i && (cnt >= PER / 2);
endmodule : pds_spindle_model

// file: testbench/pds_sequencer_tb.sv
// self-checking testbench for the pump dispense sequencer
`timescale 1ns/100ps
module pds_sequencer_tb;
  localparam int DEB = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic trig = 1'b0;
  logic stall = 1'b0;
  logic [8:0] key = 9'h000;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  wire logic [31:0] dat_o;
  wire logic [9:0] speed;
  wire logic ack, irq, spin, mrun, mrev, l_metered_dispense_mode, l_prime, l_fwd, l_rev, l_grn, l_red, l_flt;
  int n_errors = 0;
  int check_count = 0;

  pds_sequencer #(.DEB_CYC(DEB), .STALL_CYC(50)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .vol_up_i(key[0]), .vol_dn_i(key[1]), .rate_up_i(key[2]), .rate_dn_i(key[3]),
    .mode_selector_i(key[4]), .direction_selector_i(key[5]), .fault_clear_i(key[6]),
    .run_key_i(key[7]), .halt_key_i(key[8]), .trigger_i(trig), .spindle_i(spin),
    .metered_dispense_mode_lamp_o(l_metered_dispense_mode), .prime_lamp_o(l_prime),
    .forward_flow_lamp_o(l_fwd), .reverse_lamp_o(l_rev), .green_lamp_o(l_grn),
    .red_lamp_o(l_red), .fault_lamp_o(l_flt), .motor_run_o(mrun), .motor_reverse_o(mrev),
    .motor_speed_o(speed), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq));
  pds_spindle_model #(.PER(20)) far (.clk_i(clk_i), .motor_run_i(mrun), .stall_i(stall),
    .spindle_o(spin));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc_n

  // keys must outlast the debounce filter, so hold and release for 3x its length
  task automatic press(input int k);
    key[k] <= 1'b1;
    cyc_n(3 * DEB);
    key[k] <= 1'b0;
    cyc_n(3 * DEB);
  endtask : press

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, ack}, 32'h1, "no bus ack");
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wait_run(input logic v, input string m);
    int n;
    n = 0;
    while (mrun !== v && n < 1500) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, mrun}, {31'h0, v}, m);
  endtask : wait_run

  task automatic t_reset();
    logic [8:0] v;
    v = {l_red, l_grn, l_flt, l_metered_dispense_mode, l_prime, l_fwd, l_rev, mrun, irq};
    chk({23'h0, v}, 32'h128, "reset lamps");
    chk({22'h0, speed}, 32'h0, "reset speed");
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1, "ctrl reset");
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask : t_reset

  task automatic t_settings();
    press(1);
    for (int i = 0; i < 3; i++) press(0);
    press(1);
    press(2);
    press(2);
    press(3);
    bus(1'b1, 8'h08, 32'h3ff);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0001_0002, "settings value");
  endtask : t_settings

  task automatic t_prime();
    key[4] <= 1'b1;
    key[5] <= 1'b1;
    cyc_n(3 * DEB);
    chk({28'h0, l_metered_dispense_mode, l_prime, l_fwd, l_rev}, 32'h5, "selector lamps");
    press(7);
    wait_run(1'b1, "prime start");
    chk({29'h0, mrev, l_grn, l_red}, 32'h6, "reverse and green");
    chk({22'h0, speed}, 32'h1, "speed follows rate");
    cyc_n(100);
    chk({31'h0, mrun}, 32'h1, "prime keeps running");
    key[4] <= 1'b0;
    cyc_n(3 * DEB);
    wait_run(1'b0, "switch to dispense stop");
    bus(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h2, "revs after switch");
    key[5] <= 1'b0;
    key[4] <= 1'b1;
    cyc_n(3 * DEB);
    press(7);
    wait_run(1'b1, "prime restart");
    press(8);
    wait_run(1'b0, "halt stops");
    chk({30'h0, l_grn, l_red}, 32'h1, "red after halt");
    key[4] <= 1'b0;
    cyc_n(3 * DEB);
  endtask : t_prime

  task automatic t_irq_metered_dispense_mode();
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    press(7);
    wait_run(1'b1, "dispense start");
    wait_run(1'b0, "dispense stop");
    chk({31'h0, irq}, 32'h0, "masked irq");
    bus(1'b1, 8'h14, 32'h7);
    cyc_n(2);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h5, "irq status");
    cyc_n(2);
    chk({31'h0, irq}, 32'h0, "irq after read clear");
  endtask : t_irq_metered_dispense_mode

  task automatic t_trigger();
    trig <= 1'b1;
    wait_run(1'b1, "trigger start");
    wait_run(1'b0, "trigger dispense stop");
    cyc_n(100);
    chk({31'h0, mrun}, 32'h0, "held trigger restarted");
    trig <= 1'b0;
    cyc_n(3 * DEB);
    bus(1'b1, 8'h00, 32'h0);
    trig <= 1'b1;
    cyc_n(3 * DEB);
    chk({31'h0, mrun}, 32'h0, "trigger while disabled");
    trig <= 1'b0;
    cyc_n(3 * DEB);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1, "ctrl write back");
  endtask : t_trigger

  task automatic t_stall();
    int n;
    n = 0;
    stall <= 1'b1;
    press(7);
    while (l_flt !== 1'b1 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    chk({30'h0, l_flt, mrun}, 32'h2, "stall fault");
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h63, "fault status");
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h7, "fault irq status");
    press(7);
    trig <= 1'b1;
    cyc_n(3 * DEB);
    chk({31'h0, mrun}, 32'h0, "run while faulted");
    trig <= 1'b0;
    stall <= 1'b0;
    cyc_n(3 * DEB);
    press(6);
    chk({31'h0, l_flt}, 32'h0, "fault cleared");
    press(7);
    wait_run(1'b1, "run after clear");
    wait_run(1'b0, "stop after clear");
  endtask : t_stall

  initial begin
    cyc_n(20000);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    cyc_n(3);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_settings();
    t_prime();
    t_irq_metered_dispense_mode();
    t_trigger();
    t_stall();
    complete_run();
  end
endmodule : pds_sequencer_tb
